/* hdl/tcc_pkg.sv */
// Function
// - Clock-select field picks internal or external tick
// - Sixteen-bit counter steps up, down or clears
// - Counter flags TOP and BOTTOM values
// - Upper-byte location reaches the holding register, except compare A reads
// - Lower-byte access moves holding register atomically, except compare A reads
// - Each tick clears, increments or decrements counter
// - Zero clock select stops; host access remains
// - Host write beats clear and count
// - Waveform-mode field split across control registers
// - Overflow flag set per waveform mode
// - Selected source edge triggers a capture
// - Capture copies counter and sets flag together
// - Flag requests interrupt; cleared by service or one
// - Capture lower byte read loads holding register
// - Capture writes only in capture-as-TOP modes
// - Comparator select bit chooses capture source
// - Inputs synchronised; filter adds four cycles
// - Capture inputs disabled in capture-as-TOP modes
// - Filter output changes after four equal samples
// - Filter enable bit; runs on system clock
// - One holding register serves all wide registers
// - TOP is fixed value, compare A or capture
package tcc_pkg;
    // I/O addresses of the timer locations, arbitrary within this block.
    localparam logic [7:0] TCC_ADR_CNT_LO = 8'h00;
    localparam logic [7:0] TCC_ADR_CNT_HI = 8'h01;
    localparam logic [7:0] TCC_ADR_CAP_LO = 8'h02;
    localparam logic [7:0] TCC_ADR_CAP_HI = 8'h03;
    localparam logic [7:0] TCC_ADR_CMPA_LO = 8'h04;
    localparam logic [7:0] TCC_ADR_CMPA_HI = 8'h05;
    localparam logic [7:0] TCC_ADR_CTRL_A = 8'h06;
    localparam logic [7:0] TCC_ADR_CTRL_B = 8'h07;
    localparam logic [7:0] TCC_ADR_FLAGS = 8'h08;
    localparam logic [7:0] TCC_ADR_MASK = 8'h09;
    localparam logic [7:0] TCC_ADR_CMP_CTL = 8'h0a;
    // Field positions.
    localparam int TCC_B_CS_LSB = 0;
    localparam int TCC_B_WGM_LSB = 3;
    localparam int TCC_B_EDGE = 6;
    localparam int TCC_B_NC = 7;
    localparam int TCC_A_WGM_LSB = 0;
    localparam int TCC_F_OVF = 2;
    localparam int TCC_F_CAP = 5;
    localparam int TCC_ACS_SEL = 2;
    localparam int TCC_ACS_OUT = 5;
    // Fixed TOP values and limits.
    localparam logic [15:0] TCC_TOP_8B = 16'h00ff;
    localparam logic [15:0] TCC_TOP_9B = 16'h01ff;
    localparam logic [15:0] TCC_TOP_10B = 16'h03ff;
    localparam logic [15:0] TCC_MAX = 16'hffff;
    localparam logic [15:0] TCC_ZERO16 = 16'h0000;
    localparam logic [7:0] TCC_ZERO8 = 8'h00;
    localparam int TCC_NC_SAMPLES = 4;
    // Clock-select codes.
    localparam logic [2:0] TCC_CS_STOP = 3'h0;
    localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;
endpackage

/* hdl/tcc_cap_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Signals between the timer core and its capture front end.
interface tcc_cap_if;
    logic raw;
    logic enable;
    logic filter_en;
    logic rising;
    logic trigger;
    modport core (output raw, output enable, output filter_en, output rising, input trigger);
    modport front (input raw, input enable, input filter_en, input rising, output trigger);
endinterface
`default_nettype wire

/* hdl/tcc_cap_front.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_cap_front
    import tcc_pkg::*;
#(
    parameter int NSAMP = TCC_NC_SAMPLES
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    tcc_cap_if.front  cap
);
    typedef struct packed {
        logic [NSAMP-1:0] hist;
        logic             filt;
        logic             prev;
    } tcc_cf_t;
    tcc_cf_t s_q, s_d;
    logic    sel;

    // ---------------------------------------------------------------
    // Filter and edge detector
    // ---------------------------------------------------------------
    // The source is already synchronised by the core, so it is read directly.
    always_comb begin
        s_d = s_q;
        s_d.hist = {s_q.hist[NSAMP-2:0], cap.raw};
        if (&s_d.hist || ~|s_d.hist) begin
            s_d.filt = s_d.hist[0];
        end
        sel = cap.filter_en ? s_q.filt : cap.raw;
        s_d.prev = sel;
    end

    // chosen edge triggers; disabled when input is gated off.
    assign cap.trigger = cap.enable && (cap.rising ? (sel && !s_q.prev) : (!sel && s_q.prev));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* hdl/tcc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    input  wire logic       presc_tick_i,
    input  wire logic       external_clock_pin_i,
    input  wire logic       capture_pin_i,
    input  wire logic       comparator_output_i,
    input  wire logic       direction_i,
    input  wire logic       clear_i,
    input  wire logic       cap_irq_ack_i,
    output logic      [7:0] io_rdata_o,
    output logic            top_o,
    output logic            bottom_o,
    output logic            timer_tick_o,
    output logic            overflow_flag_o,
    output logic            capture_flag_o,
    output logic            capture_irq_o
);
    typedef struct packed {
        logic [1:0]  ext_sy;
        logic [1:0]  cap_sy;
        logic [1:0]  acmp_sy;
        logic        ext_prev;
        logic [15:0] count_value;
        logic [15:0] capture_value;
        logic [15:0] cmpa;
        logic [7:0]  hold;
        logic [7:0]  control_reg_a;
        logic [7:0]  control_reg_b;
        logic        comparator_capture_select;
        logic        capture_irq_enable;
        logic        overflow_flag;
        logic        capture_flag;
        logic [7:0]  rdata;
        logic        top;
        logic        bottom;
        logic        tick;
        logic        irq;
    } tcc_st_t;

    tcc_st_t     s_q, s_d;
    tcc_cap_if   cap_bus ();
    logic [3:0]  wmode;
    logic [15:0] top_val;
    logic        icr_top;
    logic        tick;
    logic        wr_en;
    logic        rd_en;

    // ---------------------------------------------------------------
    // Mode decode helpers
    // ---------------------------------------------------------------
    // TOP per waveform mode.
    function automatic logic [15:0] tcc_top(input logic [3:0] m, input logic [15:0] a,
                                            input logic [15:0] c);
        case (m)
            4'h1, 4'h5: tcc_top = TCC_TOP_8B;
            4'h2, 4'h6: tcc_top = TCC_TOP_9B;
            4'h3, 4'h7: tcc_top = TCC_TOP_10B;
            4'h4, 4'h9, 4'hb, 4'hf: tcc_top = a;
            4'h8, 4'ha, 4'hc, 4'he: tcc_top = c;
            default: tcc_top = TCC_MAX;
        endcase
    endfunction

    function automatic logic tcc_uses_icr(input logic [3:0] m);
        tcc_uses_icr = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
    endfunction

    // mode bits split across both control registers.
    assign wmode   = {s_q.control_reg_b[TCC_B_WGM_LSB+1:TCC_B_WGM_LSB],
                      s_q.control_reg_a[TCC_A_WGM_LSB+1:TCC_A_WGM_LSB]};
    assign top_val = tcc_top(wmode, s_q.cmpa, s_q.capture_value);
    assign icr_top = tcc_uses_icr(wmode);
    assign wr_en   = io_wr_i;
    assign rd_en   = io_rd_i;

    // ---------------------------------------------------------------
    // Timer tick selection
    // ---------------------------------------------------------------
    // clock-select picks prescaler or external edge; zero stops.
    always_comb begin
        case (s_q.control_reg_b[TCC_B_CS_LSB+2:TCC_B_CS_LSB])
            TCC_CS_STOP:     tick = 1'b0;
            TCC_CS_EXT_FALL: tick = s_q.ext_prev && !s_q.ext_sy[1];
            TCC_CS_EXT_RISE: tick = !s_q.ext_prev && s_q.ext_sy[1];
            default:         tick = presc_tick_i;
        endcase
    end

    // ---------------------------------------------------------------
    // Capture front end
    // ---------------------------------------------------------------
    // comparator select chooses source; both pass synchronisers.
    assign cap_bus.raw       = s_q.comparator_capture_select ? s_q.acmp_sy[1] : s_q.cap_sy[1];
    // gated off when the capture register is TOP.
    assign cap_bus.enable    = !icr_top;
    assign cap_bus.filter_en = s_q.control_reg_b[TCC_B_NC];
    assign cap_bus.rising    = s_q.control_reg_b[TCC_B_EDGE];

    tcc_cap_front #(
        .NSAMP (TCC_NC_SAMPLES)
    ) u_front (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cap     (cap_bus)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ext_sy   = {s_q.ext_sy[0], external_clock_pin_i};
        s_d.cap_sy   = {s_q.cap_sy[0], capture_pin_i};
        s_d.acmp_sy  = {s_q.acmp_sy[0], comparator_output_i};
        s_d.ext_prev = s_q.ext_sy[1];
        s_d.tick     = tick;

        // on a tick, clear or step the counter.
        if (tick) begin
            // clear zeroes, else step by one in the chosen direction.
            if (clear_i) begin
                s_d.count_value = TCC_ZERO16;
            end else if (direction_i) begin
                s_d.count_value = s_q.count_value - 16'h0001;
            end else begin
                s_d.count_value = s_q.count_value + 16'h0001;
            end
            // overflow at MAX in normal mode, at TOP counting up in other modes, at BOTTOM counting down in any mode.
            if ((wmode == 4'h0 && s_q.count_value == TCC_MAX) ||
                (wmode != 4'h0 && !direction_i && s_q.count_value == top_val) ||
                (direction_i && s_q.count_value == TCC_ZERO16)) begin
                s_d.overflow_flag = 1'b1;
            end
        end

        // capture copies counter and sets flag together.
        if (cap_bus.trigger) begin
            s_d.capture_value = s_q.count_value;
        end

        s_d.rdata = TCC_ZERO8;
        if (rd_en) begin
            if (io_addr_i == TCC_ADR_CNT_LO) begin
                s_d.rdata = s_q.count_value[7:0];
                // counter upper byte into holding register.
                s_d.hold = s_q.count_value[15:8];
            end else if (io_addr_i == TCC_ADR_CAP_LO) begin
                s_d.rdata = s_q.capture_value[7:0];
                s_d.hold = s_q.capture_value[15:8];
            end else if (io_addr_i == TCC_ADR_CNT_HI || io_addr_i == TCC_ADR_CAP_HI) begin
                // upper locations return the holding register.
                s_d.rdata = s_q.hold;
            end else if (io_addr_i == TCC_ADR_CMPA_LO) begin
                s_d.rdata = s_q.cmpa[7:0];
            end else if (io_addr_i == TCC_ADR_CMPA_HI) begin
                s_d.rdata = s_q.cmpa[15:8];
            end else if (io_addr_i == TCC_ADR_CTRL_A) begin
                s_d.rdata = s_q.control_reg_a;
            end else if (io_addr_i == TCC_ADR_CTRL_B) begin
                s_d.rdata = s_q.control_reg_b;
            end else if (io_addr_i == TCC_ADR_FLAGS) begin
                s_d.rdata[TCC_F_OVF] = s_q.overflow_flag;
                s_d.rdata[TCC_F_CAP] = s_q.capture_flag;
            end else if (io_addr_i == TCC_ADR_MASK) begin
                s_d.rdata[TCC_F_CAP] = s_q.capture_irq_enable;
            end else if (io_addr_i == TCC_ADR_CMP_CTL) begin
                s_d.rdata[TCC_ACS_SEL] = s_q.comparator_capture_select;
                s_d.rdata[TCC_ACS_OUT] = s_q.acmp_sy[1];
            end
        end

        // Flag clears: write one, or interrupt service for the capture flag.
        // clear by write-one or acknowledge; a new set still wins.
        if ((wr_en && io_addr_i == TCC_ADR_FLAGS && io_wdata_i[TCC_F_CAP]) || cap_irq_ack_i) begin
            s_d.capture_flag = 1'b0;
        end
        if (wr_en && io_addr_i == TCC_ADR_FLAGS && io_wdata_i[TCC_F_OVF]) begin
            s_d.overflow_flag = 1'b0;
        end
        if (cap_bus.trigger) begin
            s_d.capture_flag = 1'b1;
        end

        // Host writes; counter write overrides count and clear.
        if (wr_en) begin
            if (io_addr_i == TCC_ADR_CNT_HI || io_addr_i == TCC_ADR_CAP_HI ||
                io_addr_i == TCC_ADR_CMPA_HI) begin
                s_d.hold = io_wdata_i;
            end else if (io_addr_i == TCC_ADR_CNT_LO) begin
                s_d.count_value = {s_q.hold, io_wdata_i};
            end else if (io_addr_i == TCC_ADR_CAP_LO) begin
                // writable only when capture is TOP.
                if (icr_top) begin
                    s_d.capture_value = {s_q.hold, io_wdata_i};
                end
            end else if (io_addr_i == TCC_ADR_CMPA_LO) begin
                s_d.cmpa = {s_q.hold, io_wdata_i};
            end else if (io_addr_i == TCC_ADR_CTRL_A) begin
                s_d.control_reg_a = io_wdata_i;
            end else if (io_addr_i == TCC_ADR_CTRL_B) begin
                s_d.control_reg_b = io_wdata_i;
            end else if (io_addr_i == TCC_ADR_MASK) begin
                s_d.capture_irq_enable = io_wdata_i[TCC_F_CAP];
            end else if (io_addr_i == TCC_ADR_CMP_CTL) begin
                s_d.comparator_capture_select = io_wdata_i[TCC_ACS_SEL];
            end
        end

        // TOP and BOTTOM indications track the counter.
        s_d.top    = (s_d.count_value == top_val);
        s_d.bottom = (s_d.count_value == TCC_ZERO16);
        // interrupt request while enabled and flagged.
        s_d.irq    = s_d.capture_flag && s_d.capture_irq_enable;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // reset clears counter, capture, holding and flags.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata_o      = s_q.rdata;
    assign top_o           = s_q.top;
    assign bottom_o        = s_q.bottom;
    assign timer_tick_o    = s_q.tick;
    assign overflow_flag_o = s_q.overflow_flag;
    assign capture_flag_o  = s_q.capture_flag;
    assign capture_irq_o   = s_q.irq;
endmodule
`default_nettype wire

/* bench/tcc_timer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_asserts
    import tcc_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] io_addr_i,
    input wire logic       io_wr_i,
    input wire logic       io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic       presc_tick_i,
    input wire logic       cap_irq_ack_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic       timer_tick_o,
    input wire logic       overflow_flag_o,
    input wire logic       capture_flag_o,
    input wire logic       capture_irq_o
);
    logic [2:0] cs_q;
    logic       en_q;
    logic       fwr;
    // Flag register writes, shared by several properties.
    assign fwr = io_wr_i && io_addr_i == TCC_ADR_FLAGS;
    // Shadow of clock select and capture interrupt enable, so rules can be tied to them.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_q <= 3'h0;
            en_q <= 1'b0;
        end else if (io_wr_i && io_addr_i == TCC_ADR_CTRL_B) begin
            cs_q <= io_wdata_i[2:0];
        end else if (io_wr_i && io_addr_i == TCC_ADR_MASK) begin
            en_q <= io_wdata_i[TCC_F_CAP];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_presc;
        presc_tick_i && cs_q inside {[3'h1:3'h5]};
    endsequence
    property p_presc; s_presc |-> ##[1:2] timer_tick_o; endproperty
    a_presc: assert property (p_presc) else $error("prescaler tick lost");
    property p_stop;
        cs_q == 3'h0 && $past(cs_q) == 3'h0 && $past(cs_q, 2) == 3'h0 |-> !timer_tick_o;
    endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");
    property p_rd_idle; !$past(io_rd_i) |-> io_rdata_o == TCC_ZERO8; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_ovf_clr; fwr && io_wdata_i[TCC_F_OVF] |=> !overflow_flag_o; endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
    property p_ovf_hold; overflow_flag_o && !(fwr && io_wdata_i[TCC_F_OVF]) |=> overflow_flag_o;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
    property p_cap_hold;
        capture_flag_o && !(fwr && io_wdata_i[TCC_F_CAP]) && !cap_irq_ack_i |=> capture_flag_o;
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture flag dropped");
    property p_irq_flag; capture_irq_o |-> capture_flag_o || $past(capture_flag_o); endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("request without flag");
    property p_irq_rise; $rose(capture_flag_o) && en_q |-> ##[0:1] capture_irq_o; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("enabled flag gave no request");
endmodule
bind tcc_timer tcc_timer_asserts i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .presc_tick_i(presc_tick_i),
    .cap_irq_ack_i(cap_irq_ack_i), .io_rdata_o(io_rdata_o), .timer_tick_o(timer_tick_o),
    .overflow_flag_o(overflow_flag_o), .capture_flag_o(capture_flag_o),
    .capture_irq_o(capture_irq_o));
`default_nettype wire

/* bench/tcc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
    input wire logic       clk_i,
    input wire logic [7:0] io_rdata_i,
    output logic     [7:0] io_addr_o,
    output logic           io_wr_o,
    output logic           io_rd_o,
    output logic     [7:0] io_wdata_o
);
    // Idle bus at time zero.
    initial begin
        io_addr_o = 8'h00;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end
    // one access at a time; tasks never interleave, as if interrupts were off.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        io_wr_o = 1'b0;
        io_addr_o = ~a;
        io_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_i);
        #1;
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        io_rd_o = 1'b0;
        io_addr_o = ~a;
        q = io_rdata_i;
    endtask
    // upper byte written first, lower byte read first.
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo + 8'h01, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 8'h01, v[15:8]);
    endtask
endmodule
`default_nettype wire

/* bench/tcc_timer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_tb_top;
    import tcc_pkg::*;
    typedef struct packed {logic [7:0] a; logic [15:0] v; logic [15:0] e;} tcc_row_t;
    logic clk_i = 1'b0, rst_n_i = 1'b0, presc = 1'b0, ext = 1'b0, cap = 1'b0, cmp = 1'b0;
    logic dir = 1'b0, clr = 1'b0, ack = 1'b0, wr, rd, top, bot, tck, ovf, capf, irq;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] v, n0, n1;
    int errors = 0, tests_run = 0;
    tcc_row_t rows [4] = '{'{TCC_ADR_CNT_LO, 16'h1234, 16'h1234},
        '{TCC_ADR_CAP_LO, 16'habcd, 16'h0000}, '{TCC_ADR_CNT_LO, 16'h0000, 16'h0000},
        '{8'h0e, 16'h5a5a, 16'h0000}};
    always #25 clk_i = ~clk_i;
    tcc_host_model i_host (.clk_i(clk_i), .io_rdata_i(rdata), .io_addr_o(addr), .io_wr_o(wr),
        .io_rd_o(rd), .io_wdata_o(wdata));
    tcc_timer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(addr), .io_wr_i(wr),
        .io_rd_i(rd), .io_wdata_i(wdata), .presc_tick_i(presc), .external_clock_pin_i(ext),
        .capture_pin_i(cap), .comparator_output_i(cmp), .direction_i(dir), .clear_i(clr),
        .cap_irq_ack_i(ack), .io_rdata_o(rdata), .top_o(top), .bottom_o(bot),
        .timer_tick_o(tck), .overflow_flag_o(ovf), .capture_flag_o(capf), .capture_irq_o(irq));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Prescaler pulse held for n edges, so the counter steps n times.
    task automatic tick(input int n);
        step(1);
        presc = 1'b1;
        step(n);
        presc = 1'b0;
    endtask
    // capture forced by driving the pin; returns cycles until the flag shows.
    task automatic cap_lat(output logic [15:0] n);
        step(1);
        cap = 1'b1;
        n = 16'h0000;
        while (capf !== 1'b1 && n < 16'h0020) begin
            step(1);
            n++;
        end
    endtask
    // Watchdog sized well above the expected run of about two hundred cycles.
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end
    initial begin
        step(3);
        rst_n_i = 1'b1;
        step(1);
        chk(bot, 1'b1);
        i_host.rd16(TCC_ADR_CAP_LO, v);
        chk(v, 16'h0000);
        foreach (rows[i]) begin
            i_host.wr16(rows[i].a, rows[i].v);
            i_host.rd16(rows[i].a, v);
            chk(v, rows[i].e);
        end
        for (int m = 1; m < 4; m++) begin
            i_host.wr(TCC_ADR_CTRL_A, 8'(m));
            i_host.wr16(TCC_ADR_CNT_LO, (16'h0100 << (m - 1)) - 16'h0001);
            step(2);
            chk(top, 1'b1);
        end
        i_host.wr(TCC_ADR_CTRL_A, 8'h00);
        i_host.wr16(TCC_ADR_CNT_LO, 16'hfffe);
        i_host.wr(TCC_ADR_CTRL_B, 8'h01);
        tick(2);
        step(2);
        chk(ovf, 1'b1);
        chk(bot, 1'b1);
        dir = 1'b1;
        tick(1);
        chk(tck, 1'b1);
        dir = 1'b0;
        i_host.rd16(TCC_ADR_CNT_LO, v);
        chk(v, 16'hffff);
        clr = 1'b1;
        presc = 1'b1;
        i_host.wr16(TCC_ADR_CNT_LO, 16'h4321);
        presc = 1'b0;
        clr = 1'b0;
        // The first cleared tick starts at MAX and may raise overflow, so clear it afterwards.
        i_host.wr(TCC_ADR_FLAGS, 8'h04);
        i_host.wr(TCC_ADR_CTRL_B, 8'h40);
        chk(ovf, 1'b0);
        i_host.rd16(TCC_ADR_CNT_LO, v);
        chk(v, 16'h4321);
        i_host.wr(TCC_ADR_MASK, 8'h20);
        cap_lat(n0);
        chk(n0, 16'h0003);
        step(1);
        chk(irq, 1'b1);
        i_host.rd16(TCC_ADR_CAP_LO, v);
        chk(v, 16'h4321);
        ack = 1'b1;
        step(1);
        ack = 1'b0;
        chk(capf, 1'b0);
        cap = 1'b0;
        i_host.wr(TCC_ADR_CTRL_B, 8'hc0);
        step(10);
        cap = 1'b1;
        step(2);
        cap = 1'b0;
        step(12);
        chk(capf, 1'b0);
        cap_lat(n1);
        chk(n1 - n0, 16'h0004);
        i_host.wr(TCC_ADR_CTRL_B, 8'h40);
        i_host.wr(TCC_ADR_CMP_CTL, 8'h04);
        step(10);
        i_host.wr(TCC_ADR_FLAGS, 8'h20);
        cmp = 1'b1;
        step(10);
        chk(capf, 1'b1);
        i_host.wr(TCC_ADR_CMP_CTL, 8'h00);
        i_host.wr(TCC_ADR_CTRL_B, 8'h58);
        step(10);
        i_host.wr(TCC_ADR_FLAGS, 8'h20);
        i_host.wr(TCC_ADR_CAP_HI, 8'h56);
        i_host.wr(TCC_ADR_CAP_LO, 8'h11);
        i_host.wr(TCC_ADR_CNT_LO, 8'h22);
        i_host.rd16(TCC_ADR_CAP_LO, v);
        chk(v, 16'h5611);
        i_host.rd16(TCC_ADR_CNT_LO, v);
        chk(v, 16'h5622);
        cap = 1'b0;
        step(10);
        cap = 1'b1;
        step(10);
        chk(capf, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
